/* ufc_top.sv */
// Enhanced feature and flow control logic with Avalon register slave
`timescale 1ns/100ps
`default_nettype none
`include "ufc_cfg.svh"
module ufc_top
  import ufc_pkg::*;
#(
  parameter int LVL_W = 7,
  parameter logic [6:0] TRIG_STEP = 7'd8
)
(
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive path from the UART core
  input wire logic rx_valid,
  input wire ufc_byte_type rx_char,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic [LVL_W-1:0] rx_trig_level,
  output logic rx_store,
  output ufc_byte_type rx_store_char,
  // Flow character requests to the transmitter
  output logic tx_flow_valid,
  output ufc_byte_type tx_flow_char,
  input wire logic tx_flow_ready,
  output logic tx_halt,
  // Modem pins
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic rts_n,
  // Register values for the UART core
  output logic [7:0] ier_out,
  output logic [7:0] fcr_out,
  output logic [7:0] mcr_out,
  output logic [15:0] divisor,
  output logic irq
);
  ufc_byte_type efr_ff, res1_ff, res2_ff, stp1_ff, stp2_ff;
  logic [7:0] ier_ff, fcr_ff, mcr_ff;
  logic [15:0] div_ff;
  logic [4:0] evt_ff, mask_ff, evt_set;
  logic wait_ff, wr_go, rd_go, flush;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [3:0] pin_s1_ff, pin_s2_ff, pin_prev_ff, delta_ff, delta_set;
  logic [2:0] pin_fill_ff;
  logic hold_ff, hold_prev_ff, trig_ff, stopped_ff, cts_stop;
  logic rts_n_ff, halt_ff, irq_ff, store_ff, flow_valid_ff;
  ufc_byte_type store_char_ff, flow_char_ff;
  logic req_stop_ff, req_res_ff, kind_stop_ff;
  ufc_tx_state_type tx_state_ff;
  logic [LVL_W:0] hi_mark, lvl_ext;
  logic [7:0] modem_status_reg;
  ufc_match_if mif ();

  // Output wiring, all from flip-flops
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign rx_store = store_ff;
  assign rx_store_char = store_char_ff;
  assign tx_flow_valid = flow_valid_ff;
  assign tx_flow_char = flow_char_ff;
  assign tx_halt = halt_ff;
  assign rts_n = rts_n_ff;
  assign ier_out = ier_ff;
  assign fcr_out = fcr_ff;
  assign mcr_out = mcr_ff;
  assign divisor = div_ff;
  assign irq = irq_ff;

  // Bus handshake: one wait cycle, write takes effect on the answer edge
  assign wr_go = avs_write && !wait_ff;
  assign rd_go = avs_read && !wait_ff;
  assign flush = wr_go && avs_address == `UFC_OFF_EFR
    && avs_writedata[3:0] != efr_ff[3:0];
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wait_ff <= 1'b1;
    else
      wait_ff <= !((avs_read || avs_write) && wait_ff);
  end

  // Read mux, write-only characters read as zero
  assign modem_status_reg = {~pin_s2_ff, delta_ff};
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    unique case (avs_address)
      `UFC_OFF_EFR: nxt_rdata[7:0] = efr_ff;
      `UFC_OFF_IER: nxt_rdata[7:0] = ier_ff;
      `UFC_OFF_FCR: nxt_rdata[7:0] = fcr_ff;
      `UFC_OFF_MCR: nxt_rdata[7:0] = mcr_ff;
      `UFC_OFF_MSR: nxt_rdata[7:0] = modem_status_reg;
      `UFC_OFF_DIV: nxt_rdata[15:0] = div_ff;
      `UFC_OFF_EVT: nxt_rdata[4:0] = evt_ff;
      `UFC_OFF_MASK: nxt_rdata[4:0] = mask_ff;
      `UFC_OFF_STAT: nxt_rdata[3:0] = {hold_ff, stopped_ff,
        tx_state_ff != TXS_IDLE, halt_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_ff <= 32'h0000_0000;
    else if (avs_read && wait_ff)
      rdata_ff <= nxt_rdata;
  end

  // Feature and character registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      efr_ff <= `UFC_REG_RST;
      res1_ff <= `UFC_REG_RST;
      res2_ff <= `UFC_REG_RST;
      stp1_ff <= `UFC_REG_RST;
      stp2_ff <= `UFC_REG_RST;
      mask_ff <= 5'h00;
    end
    else if (wr_go)
    begin
      unique case (avs_address)
        `UFC_OFF_EFR: efr_ff <= avs_writedata[7:0];
        `UFC_OFF_RES1: res1_ff <= avs_writedata[7:0];
        `UFC_OFF_RES2: res2_ff <= avs_writedata[7:0];
        `UFC_OFF_STP1: stp1_ff <= avs_writedata[7:0];
        `UFC_OFF_STP2: stp2_ff <= avs_writedata[7:0];
        `UFC_OFF_MASK: mask_ff <= avs_writedata[4:0];
        default: mask_ff <= mask_ff;
      endcase
    end
  end

  // Registers with enhanced bits held while the enable bit is clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ier_ff <= `UFC_REG_RST;
      fcr_ff <= `UFC_REG_RST;
      mcr_ff <= `UFC_REG_RST;
    end
    else if (wr_go)
    begin
      if (avs_address == `UFC_OFF_IER)
        ier_ff <= efr_ff[`UFC_EFR_ENH] ? avs_writedata[7:0]
          : (ier_ff & `UFC_IER_ENH) | (avs_writedata[7:0] & ~`UFC_IER_ENH);
      if (avs_address == `UFC_OFF_FCR)
        fcr_ff <= efr_ff[`UFC_EFR_ENH] ? avs_writedata[7:0]
          : (fcr_ff & `UFC_FCR_ENH) | (avs_writedata[7:0] & ~`UFC_FCR_ENH);
      if (avs_address == `UFC_OFF_MCR)
        mcr_ff <= efr_ff[`UFC_EFR_ENH] ? avs_writedata[7:0]
          : (mcr_ff & `UFC_MCR_ENH) | (avs_writedata[7:0] & ~`UFC_MCR_ENH);
    end
  end

  // Baud divisor, set to one by power-up only
  always_ff @(posedge clk_sys or posedge por)
  begin
    if (por)
      div_ff <= `UFC_DIV_RST;
    else if (wr_go && avs_address == `UFC_OFF_DIV)
      div_ff <= avs_writedata[15:0];
  end

  // Modem pin synchronisers, order cts dsr ri cd
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_ff <= `UFC_PIN_RST;
      pin_s2_ff <= `UFC_PIN_RST;
      pin_prev_ff <= `UFC_PIN_RST;
      pin_fill_ff <= 3'h0;
    end
    else
    begin
      pin_fill_ff <= {pin_fill_ff[1:0], 1'b1}; // Chain holds real samples
      pin_s1_ff <= {cd_n, ri_n, dsr_n, cts_n};
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // Modem change flags, muted until the chain drops its reset value so a
  // pin resting low is not reported as a change right after reset
  assign delta_set = {4{pin_fill_ff[2]}} & {pin_s2_ff[3] != pin_prev_ff[3],
    pin_s2_ff[2] && !pin_prev_ff[2], pin_s2_ff[1:0] ^ pin_prev_ff[1:0]};
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      delta_ff <= 4'h0;
    else if (rd_go && avs_address == `UFC_OFF_MSR)
      delta_ff <= (delta_ff & ~rdata_ff[3:0]) | delta_set; // Reported only
    else
      delta_ff <= delta_ff | delta_set;
  end

  // Receive matcher
  assign mif.rx_valid = rx_valid;
  assign mif.rx_char = rx_char;
  assign mif.res1 = res1_ff;
  assign mif.res2 = res2_ff;
  assign mif.stp1 = stp1_ff;
  assign mif.stp2 = stp2_ff;
  assign mif.sel = efr_ff[3:0];
  assign mif.spec_en = efr_ff[`UFC_EFR_SPEC];
  assign mif.flush = flush;
  ufc_rx_match u_match (
    .clk_sys(clk_sys),
    .rst(rst),
    .m(mif.matcher)
  );

  // Received characters passed on to the receive FIFO
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      store_ff <= 1'b0;
      store_char_ff <= `UFC_REG_RST;
    end
    else
    begin
      store_ff <= mif.store;
      store_char_ff <= rx_char;
    end
  end

  // Remote stop state, resumed by resume char or any char when enabled
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stopped_ff <= 1'b0;
    else if (flush || efr_ff[3:0] == 4'h0)
      stopped_ff <= 1'b0;
    else if (mif.hit_stop)
      stopped_ff <= 1'b1;
    else if (mif.hit_res || (rx_valid && mcr_ff[`UFC_MCR_XANY]))
      stopped_ff <= 1'b0;
  end

  // Transmit halt from remote stop or CTS high
  assign cts_stop = efr_ff[`UFC_EFR_ACTS] && pin_s2_ff[0];
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      halt_ff <= 1'b0;
    else
      halt_ff <= stopped_ff || cts_stop;
  end

  // Fill hysteresis around the trigger level
  assign lvl_ext = {1'b0, rx_level};
  assign hi_mark = {1'b0, rx_trig_level} + {1'b0, TRIG_STEP[LVL_W-1:0]};
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      hold_ff <= 1'b0;
      hold_prev_ff <= 1'b0;
      trig_ff <= 1'b0;
    end
    else
    begin
      if (lvl_ext >= hi_mark)
        hold_ff <= 1'b1;
      else if (lvl_ext + {1'b0, TRIG_STEP[LVL_W-1:0]} < {1'b0, rx_trig_level})
        hold_ff <= 1'b0;
      hold_prev_ff <= hold_ff;
      trig_ff <= rx_level >= rx_trig_level;
    end
  end

  // RTS pin: auto flow only once software asserted it
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rts_n_ff <= 1'b1;
    else if (efr_ff[`UFC_EFR_ARTS] && mcr_ff[`UFC_MCR_RTS])
      rts_n_ff <= hold_ff;
    else
      rts_n_ff <= !mcr_ff[`UFC_MCR_RTS];
  end

  // Pending flow character requests from fill crossings
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      req_stop_ff <= 1'b0;
      req_res_ff <= 1'b0;
    end
    else if (flush || efr_ff[3:2] == 2'b00)
    begin
      req_stop_ff <= 1'b0;
      req_res_ff <= 1'b0;
    end
    else if (hold_ff && !hold_prev_ff)
    begin
      req_stop_ff <= 1'b1;
      req_res_ff <= 1'b0;
    end
    else if (!hold_ff && hold_prev_ff)
    begin
      req_res_ff <= 1'b1;
      req_stop_ff <= 1'b0;
    end
    else if (tx_state_ff == TXS_IDLE)
    begin
      req_stop_ff <= 1'b0;
      req_res_ff <= 1'b0;
    end
  end

  // Flow character sender, one or two characters per request
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      tx_state_ff <= TXS_IDLE;
      flow_valid_ff <= 1'b0;
      flow_char_ff <= `UFC_REG_RST;
      kind_stop_ff <= 1'b0;
    end
    else if (flush)
    begin
      tx_state_ff <= TXS_IDLE;
      flow_valid_ff <= 1'b0;
    end
    else
    begin
      unique case (tx_state_ff)
        TXS_IDLE:
        begin
          if (req_stop_ff || req_res_ff)
          begin
            kind_stop_ff <= req_stop_ff;
            flow_valid_ff <= 1'b1;
            tx_state_ff <= efr_ff[3] ? TXS_FIRST : TXS_SECOND;
            if (efr_ff[3])
              flow_char_ff <= req_stop_ff ? stp1_ff : res1_ff;
            else
              flow_char_ff <= req_stop_ff ? stp2_ff : res2_ff;
          end
        end
        TXS_FIRST:
        begin
          if (tx_flow_ready)
          begin
            if (efr_ff[2])
            begin
              flow_char_ff <= kind_stop_ff ? stp2_ff : res2_ff;
              tx_state_ff <= TXS_SECOND;
            end
            else
            begin
              flow_valid_ff <= 1'b0;
              tx_state_ff <= TXS_IDLE;
            end
          end
        end
        TXS_SECOND:
        begin
          if (tx_flow_ready)
          begin
            flow_valid_ff <= 1'b0;
            tx_state_ff <= TXS_IDLE;
          end
        end
      endcase
    end
  end

  // Sticky events, write one to clear, set wins
  assign evt_set = {|delta_set, trig_ff == 1'b0 && rx_level >= rx_trig_level
    && efr_ff[`UFC_EFR_ARTS], mif.hit_res,
    mif.hit_stop && ier_ff[`UFC_IER_STOPI], mif.hit_spec};
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      evt_ff <= 5'h00;
    else if (wr_go && avs_address == `UFC_OFF_EVT)
      evt_ff <= (evt_ff & ~avs_writedata[4:0]) | evt_set;
    else
      evt_ff <= evt_ff | evt_set;
  end

  // Interrupt output
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(evt_ff & mask_ff);
  end

  flow_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    efr_ff[3:0] == 4'h0 && $past(efr_ff[3:0]) == 4'h0 |-> !flow_valid_ff)
    else $error("flow char sent with flow control off");
  tx_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    flow_valid_ff && efr_ff[3:2] == 2'b01 && !$past(flush)
    |-> flow_char_ff == stp2_ff || flow_char_ff == res2_ff)
    else $error("wrong pair sent");
  enh_lock_a: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && avs_address == `UFC_OFF_IER && !efr_ff[`UFC_EFR_ENH]
    |=> ier_ff[7:4] == $past(ier_ff[7:4]))
    else $error("enhanced bits changed while locked");
  spec_evt_a: assert property (@(posedge clk_sys) disable iff (rst)
    mif.hit_spec |=> evt_ff[`UFC_EV_SPEC])
    else $error("special event not flagged");
  rts_auto_a: assert property (@(posedge clk_sys) disable iff (rst)
    efr_ff[`UFC_EFR_ARTS] && mcr_ff[`UFC_MCR_RTS] && lvl_ext >= hi_mark
    |=> ##1 rts_n_ff)
    else $error("RTS not raised above trigger");
  rts_gp_a: assert property (@(posedge clk_sys) disable iff (rst)
    !efr_ff[`UFC_EFR_ARTS] |=> rts_n_ff == !$past(mcr_ff[`UFC_MCR_RTS]))
    else $error("RTS not following modem control");
  cts_halt_a: assert property (@(posedge clk_sys) disable iff (rst)
    cts_stop |=> halt_ff)
    else $error("transmit not halted by CTS");
  flush_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
    flush |=> !stopped_ff && tx_state_ff == TXS_IDLE)
    else $error("flow state kept after select change");
  dual_cov: cover property (@(posedge clk_sys) disable iff (rst)
    tx_state_ff == TXS_FIRST ##1 tx_state_ff == TXS_SECOND);
  halt_cov: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(stopped_ff));
  irq_cov: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq_ff));
endmodule // ufc_top
`default_nettype wire

/* ufc_cfg.svh */
// Register map, field positions, reset values and behaviour list
//
// Behaviour
// - Flow select field resets to zero; zero means no transmit or receive flow control.
// - Upper select bits: 00 none, 10 first pair, 01 second pair, 11 both.
// - Lower select bits: 00 off, 10 match first pair, 01 match second pair.
// - Lower 11 with upper 10 or 01: either resume or either stop char counts.
// - Lower 11 with upper 11 or 00: resume or stop only as two-char sequence.
// - Enhanced bits of enable, fifo and modem regs writable only while enable set.
// - Reset clears all gated enhanced bits to zero.
// - Special detect compares each received char with second stop char; match flags event.
// - Matching first pair: flow control and special detect work independently.
// - Matching second pair with special detect: char not stored, stop and special events.
// - Auto RTS: event at trigger level, RTS high at one step above it.
// - Auto RTS: RTS low again once fill is below one step under trigger.
// - Auto RTS acts only when software asserted RTS; otherwise RTS is plain output.
// - Auto CTS: transmit stops while CTS high, resumes when CTS low.
// - Four write-only resume and stop character registers, reset to zero.
// - Baud divisor resets to one on power-up only, not on reset pin.
// - Modem change bits clear on reset; level bits show inverted inputs.
// - Software clears flow select before a new setting; device copes either way.
`ifndef UFC_CFG_SVH
`define UFC_CFG_SVH
`define UFC_OFF_EFR 4'h0
`define UFC_OFF_RES1 4'h1
`define UFC_OFF_RES2 4'h2
`define UFC_OFF_STP1 4'h3
`define UFC_OFF_STP2 4'h4
`define UFC_OFF_IER 4'h5
`define UFC_OFF_FCR 4'h6
`define UFC_OFF_MCR 4'h7
`define UFC_OFF_MSR 4'h8
`define UFC_OFF_DIV 4'h9
`define UFC_OFF_EVT 4'ha
`define UFC_OFF_MASK 4'hb
`define UFC_OFF_STAT 4'hc
`define UFC_EFR_ENH 4
`define UFC_EFR_SPEC 5
`define UFC_EFR_ARTS 6
`define UFC_EFR_ACTS 7
`define UFC_MCR_RTS 1
`define UFC_MCR_XANY 5
`define UFC_IER_STOPI 5
`define UFC_IER_ENH 8'hf0
`define UFC_FCR_ENH 8'h30
`define UFC_MCR_ENH 8'he4
`define UFC_EV_SPEC 0
`define UFC_EV_STOP 1
`define UFC_EV_RES 2
`define UFC_EV_TRIG 3
`define UFC_EV_MDM 4
`define UFC_REG_RST 8'h00
`define UFC_DIV_RST 16'h0001
`define UFC_PIN_RST 4'hf
`endif

/* ufc_pkg.sv */
// Types shared by the flow control block
package ufc_pkg;
  typedef logic [7:0] ufc_byte_type;
  typedef enum logic [1:0] {TXS_IDLE, TXS_FIRST, TXS_SECOND} ufc_tx_state_type;
endpackage

/* ufc_match_if.sv */
// Carrier between the top and the receive character matcher
`timescale 1ns/100ps
`default_nettype none
interface ufc_match_if;
  import ufc_pkg::*;
  logic rx_valid;
  ufc_byte_type rx_char;
  ufc_byte_type res1, res2, stp1, stp2;
  logic [3:0] sel;
  logic spec_en;
  logic flush;
  logic hit_res, hit_stop, hit_spec, store;
  modport host (output rx_valid, rx_char, res1, res2, stp1, stp2, sel,
    spec_en, flush, input hit_res, hit_stop, hit_spec, store);
  modport matcher (input rx_valid, rx_char, res1, res2, stp1, stp2, sel,
    spec_en, flush, output hit_res, hit_stop, hit_spec, store);
endinterface
`default_nettype wire

/* ufc_rx_match.sv */
// Receive character matcher for software flow control and special detect
`timescale 1ns/100ps
`default_nettype none
module ufc_rx_match
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Match carrier
  ufc_match_if.matcher m
);
  logic pend_res_ff, pend_stp_ff;
  logic dual;
  logic is_r1, is_r2, is_s1, is_s2;

  // Character compares and sequence mode
  assign is_r1 = m.rx_char == m.res1;
  assign is_r2 = m.rx_char == m.res2;
  assign is_s1 = m.rx_char == m.stp1;
  assign is_s2 = m.rx_char == m.stp2;
  assign dual = (m.sel[1:0] == 2'b11) && (m.sel[3] == m.sel[2]);

  // Match decode per receive selection
  always_comb
  begin
    m.hit_res = 1'b0;
    m.hit_stop = 1'b0;
    if (m.rx_valid)
    begin
      unique case (m.sel[1:0])
        2'b00:
        begin
          m.hit_res = 1'b0;
        end
        2'b10:
        begin
          m.hit_res = is_r1;
          m.hit_stop = is_s1;
        end
        2'b01:
        begin
          m.hit_res = is_r2;
          m.hit_stop = is_s2;
        end
        2'b11:
        begin
          if (dual)
          begin
            m.hit_res = pend_res_ff && is_r2;
            m.hit_stop = pend_stp_ff && is_s2;
          end
          else
          begin
            m.hit_res = is_r1 || is_r2;
            m.hit_stop = is_s1 || is_s2;
          end
        end
      endcase
    end
  end

  // Special detect and storage decision
  assign m.hit_spec = m.rx_valid && m.spec_en && is_s2;
  always_comb
  begin
    m.store = m.rx_valid && !m.hit_res && !m.hit_stop;
    if (dual && (is_r1 || is_s1))
      m.store = 1'b0;
    if (m.hit_spec && m.sel[1:0] != 2'b01)
      m.store = m.rx_valid;
    if (m.hit_spec && m.sel[1:0] == 2'b01)
      m.store = 1'b0;
  end

  // First half of a two-character sequence
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pend_res_ff <= 1'b0;
      pend_stp_ff <= 1'b0;
    end
    else if (m.flush)
    begin
      pend_res_ff <= 1'b0;
      pend_stp_ff <= 1'b0;
    end
    else if (m.rx_valid)
    begin
      pend_res_ff <= dual && is_r1;
      pend_stp_ff <= dual && is_s1;
    end
  end

  rx_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    m.sel[1:0] == 2'b00 |-> !m.hit_res && !m.hit_stop)
    else $error("flow match while receive flow off");
  any_pair_a: assert property (@(posedge clk_sys) disable iff (rst)
    m.rx_valid && m.sel[1:0] == 2'b11 && m.sel[3] != m.sel[2] && is_r2
    |-> m.hit_res)
    else $error("second resume char not accepted");
  seq_only_a: assert property (@(posedge clk_sys) disable iff (rst)
    m.rx_valid && dual && !pend_stp_ff |-> !m.hit_stop)
    else $error("stop seen without first char of sequence");
  spec_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
    m.hit_spec && m.sel[1:0] == 2'b10 |-> m.store)
    else $error("special char dropped in first pair mode");
  spec_drop_a: assert property (@(posedge clk_sys) disable iff (rst)
    m.hit_spec && m.sel[1:0] == 2'b01 |-> !m.store && m.hit_stop)
    else $error("special char stored in second pair mode");
  seq_cov: cover property (@(posedge clk_sys) disable iff (rst)
    dual && m.hit_stop);
endmodule // ufc_rx_match
`default_nettype wire

/* ufc_remote.sv */
// Remote station model: sends characters, takes flow characters, drives CTS
`timescale 1ns/100ps
`default_nettype none
module ufc_remote
  import ufc_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Flow characters from the device
  input wire logic tx_flow_valid,
  input wire ufc_byte_type tx_flow_char,
  output logic tx_flow_ready,
  // Characters towards the device
  output logic rx_valid,
  output ufc_byte_type rx_char,
  // Modem pin
  output logic cts_n
);
  logic [15:0] got_ff = 16'h0000;
  logic [1:0] slow_ff = 2'h0;
  logic rdy_ff = 1'b0;
  logic v_ff = 1'b0;
  ufc_byte_type c_ff = 8'h00;
  logic cts_ff = 1'b0;
  assign tx_flow_ready = rdy_ff;
  assign rx_valid = v_ff;
  assign rx_char = c_ff;
  assign cts_n = cts_ff;
  // Slow line: ready one cycle in four, keep the last two characters taken
  always @(posedge clk_sys)
  begin
    if (tx_flow_valid && rdy_ff)
      got_ff <= {got_ff[7:0], tx_flow_char};
    slow_ff <= slow_ff + 2'h1;
    rdy_ff <= (slow_ff == 2'h2);
  end
  // One character pulse; the data line shows garbage afterwards
  task send(input ufc_byte_type c);
    @(posedge clk_sys);
    v_ff <= 1'b1;
    c_ff <= c;
    @(posedge clk_sys);
    v_ff <= 1'b0;
    c_ff <= ~c;
  endtask
endmodule // ufc_remote
`default_nettype wire

/* test_uart_flow_control_features.sv */
// Self-checking bench for the flow control block
`timescale 1ns/100ps
`default_nettype none
`include "ufc_cfg.svh"
module test_uart_flow_control_features
  import ufc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat, rv;
  logic wt, rxv, rx_store, txv, txr, tx_halt, cts_n, rts_n, irq;
  ufc_byte_type rxc, st_ch, lst, txc;
  logic [6:0] lvl = 7'h00;
  logic [2:0] mdm = 3'h7;
  logic [15:0] dv;
  logic [23:0] regs;
  int fails = 0;
  int check_count = 0;
  int nst = 0;
  int n0;
  logic [7:0] ef [9] = '{8'h32, 8'h31, 8'h31, 8'h3b, 8'h37, 8'h3f, 8'h3f,
    8'h33, 8'h30};
  logic [15:0] sq [9] = '{16'h0013, 16'h0013, 16'h0014, 16'h0014,
    16'h0013, 16'h1341, 16'h1314, 16'h1314, 16'h0013};
  logic [8:0] hx = 9'h0dd;
  logic [7:0] te [4] = '{8'h18, 8'h14, 8'h1c, 8'h10};
  logic [15:0] ts [4] = '{16'h0013, 16'h0014, 16'h1314, 16'h0000};
  logic [15:0] tr [4] = '{16'h0011, 16'h0012, 16'h1112, 16'h0000};
  logic [6:0] lv [5] = '{7'h10, 7'h17, 7'h18, 7'h08, 7'h07};
  logic [4:0] rx_e = 5'h0c;
  // Clock and store counter
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (rx_store === 1'b1)
    begin
      nst <= nst + 1;
      lst <= st_ch;
    end
  ufc_top ufc_top_inst (.clk_sys(clk_sys), .rst(rst), .por(por),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wt), .rx_valid(rxv),
    .rx_char(rxc), .rx_level(lvl), .rx_trig_level(7'h10),
    .rx_store(rx_store), .rx_store_char(st_ch), .tx_flow_valid(txv),
    .tx_flow_char(txc), .tx_flow_ready(txr), .tx_halt(tx_halt),
    .cts_n(cts_n), .dsr_n(mdm[0]), .ri_n(mdm[1]), .cd_n(mdm[2]),
    .rts_n(rts_n),
    .ier_out(regs[23:16]), .fcr_out(regs[15:8]), .mcr_out(regs[7:0]),
    .divisor(dv), .irq(irq));
  ufc_remote ufc_remote_inst (.clk_sys(clk_sys), .tx_flow_valid(txv),
    .tx_flow_char(txc), .tx_flow_ready(txr), .rx_valid(rxv),
    .rx_char(rxc), .cts_n(cts_n));
  // Compare and count
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One bus access; held until waitrequest is sampled low
  task acc(input logic [3:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= {16'h0000, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wt !== 1'b0 && n < 20);
    rv = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_sys);
    if (n >= 20)
      chk(32'h0, 32'h1);
  endtask
  // Same value into the three gated registers
  task w3(input logic [7:0] v);
    for (int i = 0; i < 3; i++)
      acc(4'(`UFC_OFF_IER + i), 1'b1, {8'h00, v});
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog, far beyond the fewer than a thousand cycles the tests need
  initial
  begin
    #100000;
    fails++;
    end_sim;
  end
  // Test sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk_sys);
    acc(`UFC_OFF_EFR, 1'b0, 16'h0);
    chk(rv, 32'h0);
    chk(regs, 24'h0);
    acc(`UFC_OFF_DIV, 1'b0, 16'h0);
    chk(rv, 32'h1);
    acc(`UFC_OFF_MSR, 1'b0, 16'h0);
    chk(rv, 32'h10);
    acc(`UFC_OFF_DIV, 1'b1, 16'h1234);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk(dv, 32'h1234);
    w3(8'hff);
    chk(regs, {~`UFC_IER_ENH, ~`UFC_FCR_ENH, ~`UFC_MCR_ENH});
    acc(`UFC_OFF_EFR, 1'b1, 16'h0010);
    w3(8'hff);
    chk(regs, 24'hffffff);
    acc(`UFC_OFF_EFR, 1'b1, 16'h0000);
    w3(8'h00);
    chk(regs, {`UFC_IER_ENH, `UFC_FCR_ENH, `UFC_MCR_ENH});
    acc(`UFC_OFF_EFR, 1'b1, 16'h0010);
    w3(8'h00);
    acc(`UFC_OFF_IER, 1'b1, 16'h0020);
    acc(`UFC_OFF_MASK, 1'b1, 16'h001f);
    for (int i = 1; i < 5; i++)
      acc(4'(i), 1'b1, 16'(8'h10 + i));
    // Receive matching per select code
    for (int i = 0; i < 9; i++)
    begin
      acc(`UFC_OFF_EFR, 1'b1, 16'h0030);
      acc(`UFC_OFF_EFR, 1'b1, {8'h00, ef[i]});
      chk(tx_halt, 32'h0);
      if (sq[i][15:8] != 8'h00)
        ufc_remote_inst.send(sq[i][15:8]);
      ufc_remote_inst.send(sq[i][7:0]);
      repeat (3) @(posedge clk_sys);
      chk(tx_halt, hx[i]);
    end
    // Special character with first pair, then with second pair
    acc(`UFC_OFF_EFR, 1'b1, 16'h0030);
    acc(`UFC_OFF_EFR, 1'b1, 16'h0032);
    acc(`UFC_OFF_STAT - 4'h2, 1'b1, 16'h001f);
    n0 = nst;
    ufc_remote_inst.send(8'h14);
    repeat (3) @(posedge clk_sys);
    chk(nst - n0, 32'h1);
    chk(lst, 32'h14);
    chk(irq, 32'h1);
    acc(`UFC_OFF_EVT, 1'b0, 16'h0);
    chk(rv, 32'h1);
    acc(`UFC_OFF_EVT, 1'b1, 16'h001f);
    acc(`UFC_OFF_EFR, 1'b1, 16'h0030);
    acc(`UFC_OFF_EFR, 1'b1, 16'h0031);
    chk(irq, 32'h0);
    ufc_remote_inst.send(8'h14);
    repeat (3) @(posedge clk_sys);
    chk(nst - n0, 32'h1);
    acc(`UFC_OFF_EVT, 1'b0, 16'h0);
    chk(rv, 32'h3);
    // Flow characters sent per transmit code
    for (int i = 0; i < 4; i++)
    begin
      acc(`UFC_OFF_EFR, 1'b1, 16'h0010);
      ufc_remote_inst.got_ff <= 16'h0000;
      acc(`UFC_OFF_EFR, 1'b1, {8'h00, te[i]});
      lvl <= 7'h18;
      repeat (30) @(posedge clk_sys);
      chk(ufc_remote_inst.got_ff, ts[i]);
      ufc_remote_inst.got_ff <= 16'h0000;
      lvl <= 7'h07;
      repeat (30) @(posedge clk_sys);
      chk(ufc_remote_inst.got_ff, tr[i]);
    end
    // Automatic RTS across the thresholds
    acc(`UFC_OFF_EFR, 1'b1, 16'h0010);
    acc(`UFC_OFF_MCR, 1'b1, 16'h0002);
    repeat (3) @(posedge clk_sys);
    chk(rts_n, 32'h0);
    acc(`UFC_OFF_EFR, 1'b1, 16'h0050);
    acc(`UFC_OFF_EVT, 1'b1, 16'h001f);
    for (int i = 0; i < 5; i++)
    begin
      lvl <= lv[i];
      repeat (4) @(posedge clk_sys);
      chk(rts_n, rx_e[i]);
    end
    acc(`UFC_OFF_EVT, 1'b0, 16'h0);
    chk(rv, 32'h8);
    // Automatic CTS off, then on
    acc(`UFC_OFF_EFR, 1'b1, 16'h0010);
    ufc_remote_inst.cts_ff <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(tx_halt, 32'h0);
    acc(`UFC_OFF_EFR, 1'b1, 16'h0090);
    repeat (6) @(posedge clk_sys);
    chk(tx_halt, 32'h1);
    ufc_remote_inst.cts_ff <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(tx_halt, 32'h0);
    // Modem input change, then change bits cleared by the read
    mdm <= 3'h6;
    repeat (6) @(posedge clk_sys);
    acc(`UFC_OFF_MSR, 1'b0, 16'h0);
    chk(rv, 32'h33);
    acc(`UFC_OFF_MSR, 1'b0, 16'h0);
    chk(rv, 32'h30);
    end_sim;
  end
endmodule // test_uart_flow_control_features
`default_nettype wire
